// ==== rtl/fpsr_pkg.sv ====
// Constants, types and helpers for the fan PWM slope and acoustic ramp block
package fpsr_pkg;
   // ****************************************************************
   // Register map and reset values
   // ****************************************************************
   localparam logic [7:0] OFS_SLOPE1 = 8'h5F;
   localparam logic [7:0] OFS_SLOPE2 = 8'h60;
   localparam logic [7:0] OFS_SLOPE3 = 8'h61;
   localparam logic [7:0] OFS_RAMP_CODE_OUT1_A = 8'h62;
   localparam logic [7:0] OFS_RAMP_CODE_OUT1_B = 8'h63;
   localparam logic [7:0] OFS_CTRL = 8'h40;
   localparam logic [7:0] OFS_STAT = 8'h41;
   localparam logic [7:0] RST_SLOPE = 8'hC4;
   localparam logic [7:0] RST_RAMP_CODE_OUT1 = 8'h00;
   // Field positions
   localparam int RATE_LSB = 0;
   localparam int ALARM_EN_BIT = 3;
   localparam int SPAN_LSB = 4;
   localparam int CODE1_LSB = 0;
   localparam int EN1_BIT = 3;
   localparam int SYNC_BIT = 4;
   localparam int FLOOR_LSB = 5;
   localparam int CODE3_LSB = 0;
   localparam int EN3_BIT = 3;
   localparam int CODE2_LSB = 4;
   localparam int EN2_BIT = 7;
   localparam int LOCK_BIT = 0;
   localparam int SLOW_LSB = 1;
   localparam int AUTO_LSB = 4;
   // Timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned RAMP_SLOW_MS = 35000;
   localparam int unsigned RAMP_SPAN_STEPS = 170;
   localparam int unsigned PWM_STEPS = 255;
   localparam int unsigned SLOW_FACTOR = 4;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      ALM_IDLE = 2'b00,
      ALM_WAIT1 = 2'b01,
      ALM_WAIT2 = 2'b10,
      ALM_HELD = 2'b11
   } fpsr_alarm_type;

   typedef struct packed {
      logic [9:0] temp_q;
      logic [7:0] start;
      logic [3:0] hyst;
      logic [7:0] limit;
      logic [7:0] min_duty;
   } fpsr_chan_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fpsr_bus_type;

   typedef struct packed {
      logic [4:0][7:0] regs;
      logic lock;
      logic [2:0] slow;
      logic [2:0] auto_on;
      logic [2:0] run;
      logic [2:0][7:0] cur;
      logic [2:0][7:0] app;
      logic [2:0][7:0] phase;
      logic [2:0][23:0] pre;
      logic [2:0][27:0] slot;
      logic [2:0] pwm;
      fpsr_alarm_type [2:0] alm;
      logic [1:0] pin_sync;
      logic ext;
      logic [3:0] tach_gate;
      logic [7:0] rdata;
   } fpsr_state_type;

   // ****************************************************************
   // Lookup functions
   // ****************************************************************
   // Cycles per duty step for a rate code, rate held in tenths of hertz
   function automatic logic [23:0] pwm_div(input logic [2:0] code, input int unsigned clk);
      int unsigned dhz;
      case (code)
         3'h0: dhz = 110;
         3'h1: dhz = 147;
         3'h2: dhz = 221;
         3'h3: dhz = 294;
         3'h4: dhz = 353;
         3'h5: dhz = 441;
         3'h6: dhz = 588;
         default: dhz = 882;
      endcase
      return 24'((longint'(clk) * 10) / (dhz * PWM_STEPS));
   endfunction : pwm_div

   function automatic logic [7:0] ramp_step(input logic [2:0] code);
      case (code)
         3'h0: return 8'h01;
         3'h1: return 8'h02;
         3'h2: return 8'h03;
         3'h3: return 8'h05;
         3'h4: return 8'h08;
         3'h5: return 8'h0C;
         3'h6: return 8'h18;
         default: return 8'h30;
      endcase
   endfunction : ramp_step

   // 16384 divided by the span in degrees
   function automatic logic [13:0] span_recip(input logic [3:0] code);
      case (code)
         4'h0: return 14'h2000;
         4'h1: return 14'h199A;
         4'h2: return 14'h1333;
         4'h3: return 14'h1000;
         4'h4: return 14'h0CCD;
         4'h5: return 14'h099A;
         4'h6: return 14'h0800;
         4'h7: return 14'h0666;
         4'h8: return 14'h04CD;
         4'h9: return 14'h0400;
         4'hA: return 14'h0333;
         4'hB: return 14'h0266;
         4'hC: return 14'h0200;
         4'hD: return 14'h019A;
         4'hE: return 14'h0133;
         default: return 14'h00CD;
      endcase
   endfunction : span_recip
endpackage : fpsr_pkg

// ==== rtl/fpsr_top.sv ====
// Fan PWM generator with slope, rate, acoustic ramp, lock and thermal alarm pin
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module fpsr_top #(
   parameter int unsigned CLK_HZ = fpsr_pkg::CLK_HZ,
   parameter int unsigned RAMP_SLOT_CYC =
      (fpsr_pkg::CLK_HZ / 1000) * fpsr_pkg::RAMP_SLOW_MS / fpsr_pkg::RAMP_SPAN_STEPS
) (
   // Clock, reset, enable
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   // Register port
   input wire fpsr_pkg::fpsr_bus_type bus_in,
   output logic [7:0] rdata_out,
   // Temperature channels and monitor cycle boundary
   input wire fpsr_pkg::fpsr_chan_type [2:0] chan_in,
   input wire logic monitor_done_in,
   // Fan outputs and tach timing
   output logic [2:0] pwm_out,
   output logic [3:0] tach_gate_out,
   // Thermal alarm pin
   input wire logic thermal_alarm_pin_in,
   output logic thermal_alarm_pin_out,
   output logic thermal_alarm_pin_oe_out,
   output logic cpu_hot_signal_out
);
   // ****************************************************************
   // Parameter checks
   // ****************************************************************
   initial begin
      if (CLK_HZ < 32'd22491) begin
         $error("CLK_HZ too low for the fastest PWM rate");
      end
      if (RAMP_SLOT_CYC < 1 || RAMP_SLOT_CYC > 32'd67108863) begin
         $error("RAMP_SLOT_CYC out of range");
      end
   end

   // ****************************************************************
   // State
   // ****************************************************************
   fpsr_pkg::fpsr_state_type s_r;
   fpsr_pkg::fpsr_state_type s_nxt;
   logic [2:0][7:0] target;
   logic [2:0] ramp_en;
   logic [2:0][2:0] ramp_code;
   logic [2:0] over;
   logic [2:0] alarm_en;
   logic drive_pin;
   logic [27:0] slot_len;
   logic [9:0] dt;
   logic [23:0] prod;
   logic [23:0] scaled;
   logic [7:0] slope;
   logic [7:0] stp;
   logic write_ok;

   // Per-output register fields
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         alarm_en[i] = s_r.regs[i][fpsr_pkg::ALARM_EN_BIT];
         over[i] = chan_in[i].temp_q > {chan_in[i].limit, 2'b00};
      end
      ramp_code[0] = s_r.regs[3][fpsr_pkg::CODE1_LSB +: 3];
      ramp_code[1] = s_r.regs[4][fpsr_pkg::CODE2_LSB +: 3];
      ramp_code[2] = s_r.regs[4][fpsr_pkg::CODE3_LSB +: 3];
      ramp_en[0] = s_r.regs[3][fpsr_pkg::EN1_BIT];
      ramp_en[1] = s_r.regs[4][fpsr_pkg::EN2_BIT];
      ramp_en[2] = s_r.regs[4][fpsr_pkg::EN3_BIT];
   end

   // Pin is driven while any channel holds an alarm
   assign drive_pin = (s_r.alm[0] != fpsr_pkg::ALM_IDLE) || (s_r.alm[1] != fpsr_pkg::ALM_IDLE) ||
      (s_r.alm[2] != fpsr_pkg::ALM_IDLE);
   // Locked registers silently drop writes
   assign write_ok = bus_in.wr && !s_r.lock;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb begin
      s_nxt = s_r;
      target = '0;
      slot_len = '0;
      dt = '0;
      prod = '0;
      scaled = '0;
      slope = '0;
      stp = '0;

      // Register writes
      if (write_ok) begin
         case (bus_in.addr)
            fpsr_pkg::OFS_SLOPE1: s_nxt.regs[0] = bus_in.wdata;
            fpsr_pkg::OFS_SLOPE2: s_nxt.regs[1] = bus_in.wdata;
            fpsr_pkg::OFS_SLOPE3: s_nxt.regs[2] = bus_in.wdata;
            fpsr_pkg::OFS_RAMP_CODE_OUT1_A: s_nxt.regs[3] = bus_in.wdata;
            fpsr_pkg::OFS_RAMP_CODE_OUT1_B: s_nxt.regs[4] = bus_in.wdata;
            default: s_nxt.regs = s_r.regs;
         endcase
      end
      // Control stays writable so the lock can be set; lock only clears at reset
      if (bus_in.wr && bus_in.addr == fpsr_pkg::OFS_CTRL) begin
         s_nxt.lock = s_r.lock | bus_in.wdata[fpsr_pkg::LOCK_BIT];
         s_nxt.slow = bus_in.wdata[fpsr_pkg::SLOW_LSB +: 3];
         s_nxt.auto_on = bus_in.wdata[fpsr_pkg::AUTO_LSB +: 3];
      end

      // Read data stands only in the cycle after the strobe
      s_nxt.rdata = '0;
      if (bus_in.rd) begin
         case (bus_in.addr)
            fpsr_pkg::OFS_SLOPE1: s_nxt.rdata = s_r.regs[0];
            fpsr_pkg::OFS_SLOPE2: s_nxt.rdata = s_r.regs[1];
            fpsr_pkg::OFS_SLOPE3: s_nxt.rdata = s_r.regs[2];
            fpsr_pkg::OFS_RAMP_CODE_OUT1_A: s_nxt.rdata = s_r.regs[3];
            fpsr_pkg::OFS_RAMP_CODE_OUT1_B: s_nxt.rdata = s_r.regs[4];
            fpsr_pkg::OFS_CTRL: s_nxt.rdata = {1'b0, s_r.auto_on, s_r.slow, s_r.lock};
            fpsr_pkg::OFS_STAT: s_nxt.rdata = {3'b000, s_r.ext, drive_pin, s_r.run};
            default: s_nxt.rdata = '0;
         endcase
      end

      for (int i = 0; i < 3; i++) begin
         // Running latch: on above start, off below start minus hysteresis
         if (chan_in[i].temp_q > {chan_in[i].start, 2'b00}) begin
            s_nxt.run[i] = 1'b1;
         end else if (11'(chan_in[i].temp_q) + {5'b00000, chan_in[i].hyst, 2'b00} <
               {1'b0, chan_in[i].start, 2'b00}) begin
            s_nxt.run[i] = 1'b0;
         end

         // Linear slope from minimum at start to full at start plus span
         dt = chan_in[i].temp_q - {chan_in[i].start, 2'b00};
         prod = dt * fpsr_pkg::span_recip(s_r.regs[i][fpsr_pkg::SPAN_LSB +: 4]);
         scaled = (8'hFF - chan_in[i].min_duty) * prod[15:0];
         slope = (prod[23:16] != 8'h00) ? 8'hFF : chan_in[i].min_duty + scaled[23:16];

         if (!s_r.auto_on[i]) begin
            target[i] = chan_in[i].min_duty;
         end else if (!s_r.run[i]) begin
            // Floor below start minus hysteresis: off or minimum
            target[i] = s_r.regs[3][fpsr_pkg::FLOOR_LSB + i] ? chan_in[i].min_duty : 8'h00;
         end else if (chan_in[i].temp_q > {chan_in[i].start, 2'b00}) begin
            target[i] = slope;
         end else begin
            target[i] = chan_in[i].min_duty;
         end

         // Ramp slot timer, stretched fourfold when slow
         slot_len = s_r.slow[i] ? 28'(RAMP_SLOT_CYC * fpsr_pkg::SLOW_FACTOR) : 28'(RAMP_SLOT_CYC);
         stp = fpsr_pkg::ramp_step(ramp_code[i]);
         if (!ramp_en[i]) begin
            s_nxt.cur[i] = target[i];
            s_nxt.slot[i] = '0;
         end else if (s_r.slot[i] >= slot_len - 28'd1) begin
            s_nxt.slot[i] = '0;
            // Step toward target without overshoot
            if (target[i] > s_r.cur[i]) begin
               s_nxt.cur[i] = (target[i] - s_r.cur[i] > stp) ? s_r.cur[i] + stp : target[i];
            end else if (target[i] < s_r.cur[i]) begin
               s_nxt.cur[i] = (s_r.cur[i] - target[i] > stp) ? s_r.cur[i] - stp : target[i];
            end
         end else begin
            s_nxt.slot[i] = s_r.slot[i] + 28'd1;
         end

         // PWM: 255 steps a period, duty latched at period start to avoid glitches
         if (s_r.pre[i] >= fpsr_pkg::pwm_div(s_r.regs[i][fpsr_pkg::RATE_LSB +: 3], CLK_HZ) - 24'd1) begin
            s_nxt.pre[i] = '0;
            if (s_r.phase[i] == 8'(fpsr_pkg::PWM_STEPS - 1)) begin
               s_nxt.phase[i] = '0;
               s_nxt.app[i] = s_r.cur[i];
            end else begin
               s_nxt.phase[i] = s_r.phase[i] + 8'd1;
            end
         end else begin
            s_nxt.pre[i] = s_r.pre[i] + 24'd1;
         end
         s_nxt.pwm[i] = s_r.phase[i] < s_r.app[i];

         // Alarm per channel: must live across one whole monitoring cycle
         case (s_r.alm[i])
            fpsr_pkg::ALM_IDLE: begin
               if (alarm_en[i] && over[i]) begin
                  s_nxt.alm[i] = fpsr_pkg::ALM_WAIT1;
               end
            end
            fpsr_pkg::ALM_WAIT1: begin
               if (!alarm_en[i]) begin
                  s_nxt.alm[i] = fpsr_pkg::ALM_IDLE;
               end else if (monitor_done_in) begin
                  s_nxt.alm[i] = fpsr_pkg::ALM_WAIT2;
               end
            end
            fpsr_pkg::ALM_WAIT2: begin
               if (!alarm_en[i]) begin
                  s_nxt.alm[i] = fpsr_pkg::ALM_IDLE;
               end else if (monitor_done_in) begin
                  s_nxt.alm[i] = fpsr_pkg::ALM_HELD;
               end
            end
            fpsr_pkg::ALM_HELD: begin
               if (!alarm_en[i] || !over[i]) begin
                  s_nxt.alm[i] = fpsr_pkg::ALM_IDLE;
               end
            end
            default: s_nxt.alm[i] = fpsr_pkg::ALM_IDLE;
         endcase
      end

      // Pin input path; external throttle seen only while no channel owns the pin
      s_nxt.pin_sync = {s_r.pin_sync[0], thermal_alarm_pin_in};
      s_nxt.ext = !s_r.pin_sync[1] && (alarm_en == 3'b000) && !drive_pin;

      // Tach timing gates: tach 3 and 4 always follow output 3, tach 2 only on sync
      s_nxt.tach_gate[0] = 1'b1;
      s_nxt.tach_gate[1] = s_r.regs[3][fpsr_pkg::SYNC_BIT] ? s_r.pwm[2] : 1'b1;
      s_nxt.tach_gate[2] = s_r.pwm[2];
      s_nxt.tach_gate[3] = s_r.pwm[2];
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
         s_r <= '0;
         s_r.regs[0] <= fpsr_pkg::RST_SLOPE;
         s_r.regs[1] <= fpsr_pkg::RST_SLOPE;
         s_r.regs[2] <= fpsr_pkg::RST_SLOPE;
         s_r.regs[3] <= fpsr_pkg::RST_RAMP_CODE_OUT1;
         s_r.regs[4] <= fpsr_pkg::RST_RAMP_CODE_OUT1;
         s_r.pin_sync <= 2'b11;
         s_r.tach_gate <= 4'hF;
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign rdata_out = s_r.rdata;
   assign pwm_out = s_r.pwm;
   assign tach_gate_out = s_r.tach_gate;
   assign thermal_alarm_pin_out = 1'b0; // Open drain, only ever pulls low
   assign thermal_alarm_pin_oe_out = drive_pin;
   assign cpu_hot_signal_out = s_r.ext;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   // Write strobe aimed at a frozen acoustic register while the lock is set
   sequence locked_write;
      s_r.lock && bus_in.wr && bus_in.addr == fpsr_pkg::OFS_RAMP_CODE_OUT1_A && ce_in;
   endsequence
   // Same hazard on the first slope and rate register
   sequence locked_slope_write;
      s_r.lock && bus_in.wr && bus_in.addr == fpsr_pkg::OFS_SLOPE1 && ce_in;
   endsequence
   // Channel 1 crosses its limit while its alarm output is enabled
   sequence raise_alarm;
      ce_in && s_r.alm[0] == fpsr_pkg::ALM_IDLE && alarm_en[0] && over[0];
   endsequence
   // Outputs parked below start with the floor bit clear and no ramp running
   sequence floor_off_out1;
      ce_in && s_r.auto_on[0] && !s_r.run[0] && !s_r.regs[3][fpsr_pkg::FLOOR_LSB] && !ramp_en[0];
   endsequence
   sequence floor_off_out2;
      ce_in && s_r.auto_on[1] && !s_r.run[1] && !s_r.regs[3][fpsr_pkg::FLOOR_LSB + 1] && !ramp_en[1];
   endsequence
   sequence floor_off_out3;
      ce_in && s_r.auto_on[2] && !s_r.run[2] && !s_r.regs[3][fpsr_pkg::FLOOR_LSB + 2] && !ramp_en[2];
   endsequence
   // Output 1 parked below start with the floor bit set
   sequence floor_min_out1;
      ce_in && s_r.auto_on[0] && !s_r.run[0] && s_r.regs[3][fpsr_pkg::FLOOR_LSB] && !ramp_en[0];
   endsequence

   // Lock: frozen registers keep their value and the lock never drops by itself
   a_lock_blocks_write: assert property (locked_write |=> $stable(s_r.regs[3]))
      else $error("locked register changed");
   a_lock_blocks_slope: assert property (locked_slope_write |=> $stable(s_r.regs[0]))
      else $error("locked slope register changed");
   a_lock_stays_set: assert property (ce_in && s_r.lock |=> s_r.lock)
      else $error("lock dropped without reset");

   // Alarm pin: assert, minimum hold, release and input mode
   a_alarm_goes_low: assert property (raise_alarm |=> thermal_alarm_pin_oe_out)
      else $error("alarm pin not driven after limit exceeded");
   a_alarm_release_ok: assert property ($fell(s_r.alm[0] != fpsr_pkg::ALM_IDLE) |->
         $past(!over[0] || !alarm_en[0]))
      else $error("alarm released while still over limit");
   a_alarm_min_hold: assert property (s_r.alm[0] == fpsr_pkg::ALM_WAIT1 && alarm_en[0] && ce_in |=>
         s_r.alm[0] != fpsr_pkg::ALM_IDLE)
      else $error("alarm released before a monitoring cycle");
   a_alarm_bit_clear: assert property (ce_in && !alarm_en[0] |=> s_r.alm[0] == fpsr_pkg::ALM_IDLE)
      else $error("alarm held with output bit clear");
   a_pin_input_mode: assert property (ce_in && alarm_en == 3'b000 |=> !thermal_alarm_pin_oe_out)
      else $error("pin driven while configured as input");

   // Duty path: jumps without ramp, bounded steps with ramp
   a_no_ramp_jump: assert property (!ramp_en[1] && ce_in |=> s_r.cur[1] == $past(target[1]))
      else $error("unramped duty did not follow target");
   a_no_jump_out3: assert property (!ramp_en[2] && ce_in |=> s_r.cur[2] == $past(target[2]))
      else $error("unramped output 3 did not follow target");
   a_ramp_step_bound: assert property (ramp_en[0] && ce_in |=>
         ((s_r.cur[0] >= $past(s_r.cur[0])) ? (s_r.cur[0] - $past(s_r.cur[0])) :
         ($past(s_r.cur[0]) - s_r.cur[0])) <= fpsr_pkg::ramp_step($past(ramp_code[0])))
      else $error("ramp step larger than the selected code");
   a_full_duty_high: assert property (ce_in && s_r.app[0] == 8'hFF |=> pwm_out[0])
      else $error("full duty output went low");

   // Floor below start minus hysteresis, checked once the state has settled
   a_floor_off: assert property (floor_off_out1 ##1 floor_off_out1 |=> s_r.cur[0] == 8'h00)
      else $error("output 1 not off below start");
   a_floor_off_out2: assert property (floor_off_out2 ##1 floor_off_out2 |=> s_r.cur[1] == 8'h00)
      else $error("output 2 not off below start");
   a_floor_off_out3: assert property (floor_off_out3 ##1 floor_off_out3 |=> s_r.cur[2] == 8'h00)
      else $error("output 3 not off below start");
   a_floor_min: assert property (floor_min_out1 ##1 floor_min_out1 |=>
         s_r.cur[0] == $past(chan_in[0].min_duty))
      else $error("output 1 not at minimum below start");

   // Tach windows against output 3
   a_tach_sync_gate: assert property (ce_in && s_r.regs[3][fpsr_pkg::SYNC_BIT] |=>
         tach_gate_out[1] == $past(s_r.pwm[2]))
      else $error("tach 2 not timed to output 3");
   a_tach_free_gate: assert property (ce_in && !s_r.regs[3][fpsr_pkg::SYNC_BIT] |=> tach_gate_out[1])
      else $error("tach 2 gated without sync");
   a_tach_out3_gate: assert property (ce_in |=> tach_gate_out[3] == $past(s_r.pwm[2]))
      else $error("tach 4 not timed to output 3");
endmodule : fpsr_top
`default_nettype wire

// ==== testbench/fpsr_fan_model.sv ====
// Model of the shared thermal alarm wire with its pull-up and an outside party
`timescale 1ns/10ps
`default_nettype none
module fpsr_fan_model (
   // Device side of the pin
   input wire logic pin_oe_in,
   input wire logic pin_drv_in,
   // Outside party pulling the line low
   input wire logic ext_low_in,
   // Resolved wire level
   output logic pin_out
);
   // Wired-AND with pull-up: a released line never keeps the last driven level
   assign pin_out = ((pin_oe_in && !pin_drv_in) || ext_low_in) ? 1'b0 : 1'b1;
endmodule : fpsr_fan_model
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the fan PWM slope and acoustic ramp block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module testbench;
   // ****************************************************************
   // Clock, stimulus and design
   // ****************************************************************
   logic core_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic ce = 1'b1;
   fpsr_pkg::fpsr_bus_type bus = '0;
   fpsr_pkg::fpsr_chan_type [2:0] chan = '0;
   logic mon_done = 1'b0;
   logic ext_low = 1'b0;
   logic [7:0] rdata;
   logic [2:0] pwm;
   logic [3:0] gate;
   logic pin, pin_drv, pin_oe, cpu_hot;
   int error_cnt = 0;
   int compares = 0;
   int st[8] = '{8, 6, 3, 3, 2, 2, 1, 1};
   int c;
   // Half period of 5 ns gives 100 MHz
   always #5 core_clk_in = ~core_clk_in;
   // Low clock figure makes the fastest rate one cycle per duty step, so a period is 255 cycles
   fpsr_top #(.CLK_HZ(22491), .RAMP_SLOT_CYC(40)) DUT (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .ce_in(ce), .bus_in(bus), .rdata_out(rdata), .chan_in(chan), .monitor_done_in(mon_done),
      .pwm_out(pwm), .tach_gate_out(gate), .thermal_alarm_pin_in(pin), .thermal_alarm_pin_out(pin_drv),
      .thermal_alarm_pin_oe_out(pin_oe), .cpu_hot_signal_out(cpu_hot));
   fpsr_fan_model fans (.pin_oe_in(pin_oe), .pin_drv_in(pin_drv), .ext_low_in(ext_low), .pin_out(pin));

   // ****************************************************************
   // Bus and measurement tasks
   // ****************************************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk_in);
      bus.wr <= 1'b0;
   endtask : wr
   // Read data is only valid in the cycle after the strobe, so it is taken right there
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk_in);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk_in);
      bus.rd <= 1'b0;
      #1;
      `CHK("rdata", e, rdata)
   endtask : rd_chk
   // Counts high cycles of one output bit; a window of one period is phase independent
   task automatic meas(input int sel, input int n, output int cnt);
      logic [6:0] v;
      cnt = 0;
      repeat (n) begin
         @(posedge core_clk_in);
         #1;
         v = {gate, pwm};
         cnt += int'(v[sel]);
      end
   endtask : meas
   task automatic settle_meas(input int sel, input int w, input int n, input int e, input string nm);
      int cnt;
      repeat (w) @(posedge core_clk_in);
      meas(sel, n, cnt);
      `CHK(nm, e, cnt)
   endtask : settle_meas

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_regs;
      rd_chk(8'h5F, 8'hC4);
      rd_chk(8'h60, 8'hC4);
      rd_chk(8'h61, 8'hC4);
      rd_chk(8'h62, 8'h00);
      rd_chk(8'h63, 8'h00);
      rd_chk(8'h7F, 8'h00);
      wr(8'h63, 8'hA5);
      rd_chk(8'h63, 8'hA5);
      wr(8'h63, 8'h00);
      // A write while the enable is low must not land
      ce <= 1'b0;
      wr(8'h63, 8'h5A);
      ce <= 1'b1;
      rd_chk(8'h63, 8'h00);
   endtask : t_regs
   // Every rate code: duty 0x80 gives 128 high steps of st[k] cycles each
   task automatic t_rates;
      chan[0].min_duty <= 8'h80;
      for (int k = 0; k < 8; k++) begin
         wr(8'h5F, {4'hC, 1'b0, 3'(k)});
         settle_meas(0, 4080, 255 * st[k], 128 * st[k], "pwm1 high");
      end
   endtask : t_rates
   task automatic t_ramp;
      chan[0].min_duty <= 8'h00;
      settle_meas(0, 600, 255, 0, "pwm1 off");
      chan[0].min_duty <= 8'h30;
      settle_meas(0, 600, 255, 48, "pwm1 jump");
      wr(8'h62, 8'h08);
      chan[0].min_duty <= 8'h00;
      settle_meas(0, 2300, 255, 0, "pwm1 ramp down");
      chan[0].min_duty <= 8'h30;
      repeat (510) @(posedge core_clk_in);
      meas(0, 255, c);
      // One step per 40-cycle slot cannot reach 48 within three periods
      `CHK("pwm1 ramp mid", 1'b1, (c > 0 && c < 48))
      wr(8'h62, 8'h0F);
      chan[0].min_duty <= 8'h00;
      settle_meas(0, 600, 255, 0, "pwm1 fast ramp");
   endtask : t_ramp
   task automatic t_floor;
      wr(8'h62, 8'h00);
      wr(8'h40, 8'h10);
      chan[0] <= '{temp_q: 10'h000, start: 8'h32, hyst: 4'h4, limit: 8'hFF, min_duty: 8'h40};
      settle_meas(0, 600, 255, 0, "floor off");
      wr(8'h62, 8'h20);
      settle_meas(0, 600, 255, 64, "floor min");
      wr(8'h5F, 8'h07);
      chan[0].temp_q <= 10'h168;
      settle_meas(0, 600, 255, 255, "slope full");
      wr(8'h40, 8'h00);
      chan[0].temp_q <= 10'h000;
   endtask : t_floor
   task automatic t_tach;
      wr(8'h61, 8'hC7);
      chan[2].min_duty <= 8'h80;
      wr(8'h62, 8'h10);
      settle_meas(4, 600, 255, 128, "speed_input_2 sync");
      settle_meas(6, 0, 255, 128, "speed_input_4 sync");
      wr(8'h62, 8'h00);
      settle_meas(4, 600, 255, 255, "speed_input_2 free");
      settle_meas(5, 0, 255, 128, "speed_input_3 free");
   endtask : t_tach
   task automatic t_alarm;
      chan[0].limit <= 8'h50;
      wr(8'h5F, 8'hCC);
      chan[0].temp_q <= 10'h141;
      repeat (2) @(posedge core_clk_in);
      #1;
      `CHK("alarm oe", 1'b1, pin_oe)
      `CHK("alarm pin", 1'b0, pin)
      chan[0].temp_q <= 10'h140;
      repeat (4) @(posedge core_clk_in);
      #1;
      `CHK("alarm held", 1'b1, pin_oe)
      repeat (2) begin
         @(posedge core_clk_in);
         mon_done <= 1'b1;
         @(posedge core_clk_in);
         mon_done <= 1'b0;
      end
      repeat (3) @(posedge core_clk_in);
      #1;
      `CHK("alarm released", 1'b0, pin_oe)
      wr(8'h5F, 8'hC4);
      chan[0].temp_q <= 10'h141;
      ext_low <= 1'b1;
      repeat (5) @(posedge core_clk_in);
      #1;
      `CHK("pin as input", 1'b0, pin_oe)
      `CHK("outside alarm", 1'b1, cpu_hot)
      ext_low <= 1'b0;
      chan[0].temp_q <= 10'h000;
   endtask : t_alarm
   // Lock is set-only, so this runs last
   task automatic t_lock;
      wr(8'h62, 8'h20);
      wr(8'h40, 8'h01);
      wr(8'h62, 8'hFF);
      rd_chk(8'h62, 8'h20);
      wr(8'h5F, 8'h00);
      rd_chk(8'h5F, 8'hC4);
   endtask : t_lock

   // ****************************************************************
   // Sequence, watchdog and verdict
   // ****************************************************************
   task automatic report_and_stop;
      $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (5) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      t_regs();
      t_rates();
      t_ramp();
      t_floor();
      t_tach();
      t_alarm();
      t_lock();
      report_and_stop();
   end
   // A hang counts as a mismatch
   initial begin
      repeat (100000) @(posedge core_clk_in);
      error_cnt++;
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
